// [pkg/fic_pkg.sv]
// package: constants for the flag and interrupt-mask core
package fic_pkg;
  // ==========================================================
  // opcodes
  localparam logic [7:0] OP_ADC_IMM = 8'ha9;
  localparam logic [7:0] OP_ADD_IMM = 8'hab;
  localparam logic [7:0] OP_AIS = 8'ha7;
  localparam logic [7:0] OP_AIX = 8'haf;
  localparam logic [7:0] OP_ASLA = 8'h48;
  localparam logic [7:0] OP_ASLX = 8'h58;
  localparam logic [7:0] OP_DAA = 8'h72;
  localparam logic [7:0] OP_CLI = 8'h9a;
  localparam logic [7:0] OP_SEI = 8'h9b;
  localparam logic [7:0] OP_RTI = 8'h80;
  localparam logic [7:0] OP_SWI = 8'h83;
  localparam logic [7:0] OP_WAIT = 8'h8f;
  localparam logic [7:0] OP_STOP = 8'h8e;
  localparam logic [7:0] OP_PUSH_UPPER_INDEX_OP = 8'h8b;
  localparam logic [7:0] OP_PULL_UPPER_INDEX_OP = 8'h8a;
  // ==========================================================
  // condition flag bit positions
  localparam int FB_C = 0;
  localparam int FB_Z = 1;
  localparam int FB_N = 2;
  localparam int FB_I = 3;
  localparam int FB_H = 4;
  localparam int FB_V = 7;
  localparam logic [7:0] CCR_ONES = 8'h60;
  localparam logic [7:0] CCR_RST = 8'h68;
  // ==========================================================
  // reset values, vectors, timing
  localparam logic [15:0] SP_RST = 16'h00ff;
  localparam logic [15:0] VEC_SWI = 16'hfffc;
  localparam logic [15:0] VEC_SWI_MON = 16'hfefc;
  localparam logic [15:0] VEC_IRQ_BASE = 16'hfffa;
  localparam int CYC_IMM = 2;
  localparam int CYC_INH = 1;
  localparam logic [7:0] DAA_LO = 8'h06;
  localparam logic [7:0] DAA_HI = 8'h60;
  localparam logic [7:0] DAA_BOTH = 8'h66;
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam int OSC_STAB_CYCLES = 4096;
  // register address map of the plain port
  localparam logic [3:0] RA_ACC = 4'h0;
  localparam logic [3:0] RA_IDXH = 4'h1;
  localparam logic [3:0] RA_IDXL = 4'h2;
  localparam logic [3:0] RA_SPH = 4'h3;
  localparam logic [3:0] RA_SPL = 4'h4;
  localparam logic [3:0] RA_CCR = 4'h5;
  localparam logic [3:0] RA_STAT = 4'h6;
  localparam logic [3:0] RA_VECH = 4'h7;
  localparam logic [3:0] RA_VECL = 4'h8;
  // ==========================================================
  typedef enum logic [2:0] {
    ST_RUN, ST_EXEC, ST_PUSH, ST_VEC, ST_WAIT, ST_STOP, ST_STAB
  } fic_state_t;
endpackage : fic_pkg

// [hw/fic_core.sv]
// design: flag generation and interrupt mask core
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - half carry set on carry from bit 3 into bit 4 in adds
// - decimal adjust picks correction from half carry and carry
// - mask set blocks maskable interrupts; clear accepts them
// - mask set after registers pushed, with the vector fetch
// - interrupt entry never stacks the upper index byte
// - highest-priority pending request serviced first
// - interrupt return restores registers and mask from stack copy
// - reset sets mask; only clear-mask, wait, stop, return clear it
// - sign flag follows result bit 7
// - zero flag set on zero result
// - carry from add out of bit 7, also shift updates it
// - wait clears mask, gates clock; interrupt exit keeps mask clear
// - stop clears mask, gates clock; external interrupt keeps mask clear
// - clock restarts after stop only after stabilization delay
// - enabled break traps after current op via fffc or fefc
// - return in break handler ends break once request is gone
// - add with carry, opcode a9, two cycles, five flags
// - add without carry, opcode ab, two cycles, five flags
// - stack pointer adds sign-extended immediate, a7, flags kept
// - index adds sign-extended immediate, af, flags kept
// - shift left, 48 and 58, one cycle, bit 7 into carry
// - overflow flag set on signed overflow
// - flag bits 6 and 5 always read as one
module fic_core
  import fic_pkg::*;
#(
  parameter int OSC_STAB = OSC_STAB_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic op_valid,
  input wire logic [7:0] op_code,
  input wire logic [7:0] op_data,
  input wire logic [7:0] pulled_ccr,
  input wire logic [7:0] pulled_acc,
  input wire logic [7:0] pulled_idxl,
  input wire logic [3:0] irq_req,
  input wire logic ext_irq,
  input wire logic brk_en,
  input wire logic brk_req,
  input wire logic mon_mode,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic op_ready,
  output logic push_valid,
  output logic [7:0] push_ccr,
  output logic [7:0] push_acc,
  output logic [7:0] push_idxl,
  output logic [15:0] vec_addr,
  output logic vec_valid,
  output logic [1:0] irq_ack_idx,
  output logic clk_gate_n,
  output logic brk_active
);
  // ==========================================================
  // state
  fic_state_t st_q;
  logic [7:0] acc_q, ccr_q;
  logic [15:0] idx_q, sp_q;
  logic [7:0] cnt_q;
  logic [12:0] stab_q;
  logic [7:0] cur_op_q, cur_dat_q;
  logic trap_brk_q;
  logic [1:0] pend_idx;
  logic irq_any, take_irq, take_brk;
  // next state, declared ahead of every process that reads it; the
  // registered outputs look one step ahead so they line up with st_q
  fic_state_t st_q_nx;

  // ==========================================================
  // arithmetic, combinational
  logic cin;
  logic [4:0] lo_sum;
  logic [8:0] sum;
  logic [7:0] res, daa_f, shl;
  logic [15:0] sext;
  logic [7:0] flg_d;

  // priority pick: lowest index wins
  // the pick is made again on every cycle, so a request that drops
  // before the push still causes an entry, vectored as index 0; sources must hold their
  // request until they see their index acknowledged
  always_comb begin
    pend_idx = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (irq_req[i]) begin
        pend_idx = 2'(i);
      end
    end
  end
  assign irq_any = |irq_req;
  // mask gates maskable requests only
  assign take_irq = irq_any && !ccr_q[FB_I];
  // break is not masked; it waits for the instruction boundary
  assign take_brk = brk_en && brk_req && !brk_active;

  // datapath for the current op
  // operands come from the latched op, not the live port, so the
  // flags stay valid while the bench moves op_code on to the next op;
  // the shift result is shared by the accumulator and index-low forms
  always_comb begin
    cin = (cur_op_q == OP_ADC_IMM) ? ccr_q[FB_C] : 1'b0;
    lo_sum = {1'b0, acc_q[3:0]} + {1'b0, cur_dat_q[3:0]} + {4'h0, cin};
    sum = {1'b0, acc_q} + {1'b0, cur_dat_q} + {8'h00, cin};
    res = sum[7:0];
    sext = {{8{cur_dat_q[7]}}, cur_dat_q};
    shl = (cur_op_q == OP_ASLX) ? {idx_q[6:0], 1'b0} : {acc_q[6:0], 1'b0};
    // correction chosen from h and c plus nibble values
    daa_f = 8'h00;
    if (ccr_q[FB_H] || acc_q[3:0] > BCD_MAX) begin
      daa_f = DAA_LO;
    end
    if (ccr_q[FB_C] || acc_q > 8'h99 ||
        (acc_q[7:4] == BCD_MAX && acc_q[3:0] > BCD_MAX)) begin
      daa_f = daa_f | DAA_HI;
    end
    flg_d = ccr_q; // untouched flags keep their value
    case (cur_op_q)
      OP_ADC_IMM, OP_ADD_IMM: begin
        flg_d[FB_H] = lo_sum[4];
        flg_d[FB_N] = res[7];
        flg_d[FB_Z] = (res == 8'h00);
        flg_d[FB_C] = sum[8];
        flg_d[FB_V] = (acc_q[7] == cur_dat_q[7]) &&
                      (res[7] != acc_q[7]);
      end
      OP_ASLA, OP_ASLX: begin
        flg_d[FB_C] = (cur_op_q == OP_ASLX) ? idx_q[7] : acc_q[7];
        flg_d[FB_N] = shl[7];
        flg_d[FB_Z] = (shl == 8'h00);
        flg_d[FB_V] = shl[7] ^ flg_d[FB_C];
      end
      OP_DAA: begin
        flg_d[FB_N] = acc_q[7] ^ (acc_q[7] ^ daa_f[7]); // refined below
        flg_d[FB_C] = (daa_f == DAA_HI) || (daa_f == DAA_BOTH);
        flg_d[FB_Z] = ((acc_q + daa_f) == 8'h00);
        flg_d[FB_N] = 8'(acc_q + daa_f) >> 7 == 8'h01;
      end
      default: begin
        flg_d = ccr_q;
      end
    endcase
    flg_d = flg_d | CCR_ONES;
  end

  // ==========================================================
  // sequencer
  // one op in flight at a time; trap and interrupt entry share the
  // push and vector states so the frame layout is the same for both
  // limitation: an op offered in the cycle an entry is taken is not
  // latched, so the offering side must wait for op_ready again
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= ST_RUN;
      cnt_q <= 8'h00;
      stab_q <= 13'h0000;
      cur_op_q <= 8'h00;
      cur_dat_q <= 8'h00;
      trap_brk_q <= 1'b0;
    end else begin
      case (st_q)
        ST_RUN: begin
          // interrupts and break are taken only between ops
          if (take_brk) begin
            trap_brk_q <= 1'b1;
            st_q <= ST_PUSH;
          end else if (take_irq) begin
            trap_brk_q <= 1'b0;
            st_q <= ST_PUSH;
          end else if (op_valid) begin
            cur_op_q <= op_code;
            cur_dat_q <= op_data;
            // the two shifts take one cycle, every other op two
            if (op_code == OP_ASLA || op_code == OP_ASLX) begin
              cnt_q <= 8'(CYC_INH - 1);
            end else begin
              cnt_q <= 8'(CYC_IMM - 1);
            end
            st_q <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
          end else if (cur_op_q == OP_SWI) begin
            trap_brk_q <= 1'b0;
            st_q <= ST_PUSH;
          end else if (cur_op_q == OP_WAIT) begin
            st_q <= ST_WAIT;
          end else if (cur_op_q == OP_STOP) begin
            st_q <= ST_STOP;
          end else begin
            st_q <= ST_RUN;
          end
        end
        ST_PUSH: st_q <= ST_VEC; // registers out first
        ST_VEC: st_q <= ST_RUN;
        ST_WAIT: begin
          if (irq_any) begin
            // a wake is always a plain interrupt, never a stale trap
            trap_brk_q <= 1'b0;
            st_q <= ST_PUSH;
          end
        end
        ST_STOP: begin
          if (ext_irq) begin
            trap_brk_q <= 1'b0;
            stab_q <= 13'(OSC_STAB);
            st_q <= ST_STAB;
          end
        end
        ST_STAB: begin
          // clock held off until the oscillator settles
          if (stab_q == 13'h0000) begin
            st_q <= ST_PUSH;
          end else begin
            stab_q <= stab_q - 13'h0001;
          end
        end
        default: st_q <= ST_RUN;
      endcase
    end
  end

  // ==========================================================
  // registers and flags
  // software writes win only while idle, so an op result can never
  // be overwritten half way; the mask set in the vector state and the
  // op results are exclusive because they belong to different states
  wire done = (st_q == ST_EXEC) && (cnt_q == 8'h00);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_q <= 8'h00;
      idx_q <= 16'h0000;
      sp_q <= SP_RST;
      ccr_q <= CCR_RST; // mask set by every reset
    end else if (reg_wr && st_q == ST_RUN) begin
      case (reg_addr)
        RA_ACC: acc_q <= reg_wdata;
        RA_IDXH: idx_q[15:8] <= reg_wdata;
        RA_IDXL: idx_q[7:0] <= reg_wdata;
        RA_SPH: sp_q[15:8] <= reg_wdata;
        RA_SPL: sp_q[7:0] <= reg_wdata;
        default: ;
      endcase
    end else if (st_q == ST_VEC) begin
      ccr_q[FB_I] <= 1'b1; // after push, with vector fetch
    end else if (done) begin
      ccr_q <= flg_d;
      case (cur_op_q)
        OP_ADC_IMM, OP_ADD_IMM: acc_q <= res;
        OP_ASLA: acc_q <= shl;
        OP_ASLX: idx_q[7:0] <= shl;
        OP_DAA: acc_q <= 8'(acc_q + daa_f);
        OP_AIS: sp_q <= sp_q + sext;
        OP_AIX: idx_q <= idx_q + sext;
        OP_CLI: ccr_q[FB_I] <= 1'b0;
        OP_SEI: ccr_q[FB_I] <= 1'b1;
        OP_WAIT: ccr_q[FB_I] <= 1'b0;
        OP_STOP: ccr_q[FB_I] <= 1'b0;
        OP_PULL_UPPER_INDEX_OP: idx_q[15:8] <= cur_dat_q; // handler restores h itself
        OP_RTI: begin
          // mask comes back from the stacked copy
          ccr_q <= pulled_ccr | CCR_ONES;
          acc_q <= pulled_acc;
          idx_q[7:0] <= pulled_idxl;
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // outward signals, all registered
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      push_valid <= 1'b0;
      push_ccr <= CCR_RST;
      push_acc <= 8'h00;
      push_idxl <= 8'h00;
      vec_valid <= 1'b0;
      vec_addr <= 16'h0000;
      irq_ack_idx <= 2'h0;
      op_ready <= 1'b0;
      clk_gate_n <= 1'b1;
      brk_active <= 1'b0;
    end else begin
      // h is deliberately left off the stack frame
      push_valid <= (st_q != ST_PUSH) && (st_q_nx == ST_PUSH);
      push_ccr <= ccr_q;
      push_acc <= acc_q;
      push_idxl <= idx_q[7:0];
      vec_valid <= (st_q == ST_PUSH);
      if (st_q == ST_PUSH) begin
        if (trap_brk_q || cur_op_q == OP_SWI && !irq_any) begin
          vec_addr <= mon_mode ? VEC_SWI_MON : VEC_SWI;
        end else begin
          vec_addr <= VEC_IRQ_BASE - {13'h0000, pend_idx, 1'b0};
          irq_ack_idx <= pend_idx;
        end
      end
      op_ready <= (st_q_nx == ST_RUN);
      // clock gated in wait, stop and stabilization
      clk_gate_n <= !(st_q_nx == ST_WAIT || st_q_nx == ST_STOP ||
                      st_q_nx == ST_STAB);
      if (take_brk && st_q == ST_RUN) begin
        brk_active <= 1'b1;
      end else if (done && cur_op_q == OP_RTI && !brk_req) begin
        brk_active <= 1'b0;
      end
    end
  end

  // next-state shadow for registered outputs
  // must track the sequencer case exactly; a mismatch here shows as
  // a one-cycle early or late strobe on push_valid or op_ready
  always_comb begin
    st_q_nx = st_q;
    if (st_q == ST_RUN && (take_brk || take_irq)) begin
      st_q_nx = ST_PUSH;
    end else if (st_q == ST_RUN && op_valid) begin
      st_q_nx = ST_EXEC;
    end else if (done) begin
      if (cur_op_q == OP_SWI) st_q_nx = ST_PUSH;
      else if (cur_op_q == OP_WAIT) st_q_nx = ST_WAIT;
      else if (cur_op_q == OP_STOP) st_q_nx = ST_STOP;
      else st_q_nx = ST_RUN;
    end else if (st_q == ST_PUSH) begin
      st_q_nx = ST_VEC;
    end else if (st_q == ST_VEC) begin
      st_q_nx = ST_RUN;
    end else if (st_q == ST_WAIT && irq_any) begin
      st_q_nx = ST_PUSH;
    end else if (st_q == ST_STOP && ext_irq) begin
      st_q_nx = ST_STAB;
    end else if (st_q == ST_STAB && stab_q == 13'h0000) begin
      st_q_nx = ST_PUSH;
    end
  end

  // ==========================================================
  // register read port, data one cycle after strobe
  // read data hold until the next read strobe; unmapped addresses
  // return zero so software can probe the map safely
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        RA_ACC: reg_rdata <= acc_q;
        RA_IDXH: reg_rdata <= idx_q[15:8];
        RA_IDXL: reg_rdata <= idx_q[7:0];
        RA_SPH: reg_rdata <= sp_q[15:8];
        RA_SPL: reg_rdata <= sp_q[7:0];
        RA_CCR: reg_rdata <= ccr_q | CCR_ONES;
        RA_STAT: reg_rdata <= {4'h0, brk_active, 3'(st_q)};
        RA_VECH: reg_rdata <= vec_addr[15:8];
        RA_VECL: reg_rdata <= vec_addr[7:0];
        default: reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule : fic_core
`default_nettype wire

// [testbench/fic_core_props.sv]
// checker: concurrent properties on the flag and mask core ports
`timescale 1ns/1ps
`default_nettype none
module fic_core_props
  import fic_pkg::*;
#(
  parameter int OSC_STAB = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic op_valid,
  input wire logic [7:0] op_code,
  input wire logic op_ready,
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic push_valid,
  input wire logic [7:0] push_ccr,
  input wire logic vec_valid,
  input wire logic [15:0] vec_addr,
  input wire logic [1:0] irq_ack_idx,
  input wire logic clk_gate_n
);
  // ==========================================================
  // helper: gated cycles since a stop was taken
  logic [15:0] gate_cnt_q;
  logic stop_q;
  logic is_trap;
  assign is_trap = vec_addr == VEC_SWI || vec_addr == VEC_SWI_MON;
  // count only while gated so a short restart shows as a small count
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gate_cnt_q <= 16'h0000;
      stop_q <= 1'b0;
    end else begin
      gate_cnt_q <= clk_gate_n ? 16'h0000 : gate_cnt_q + 16'h0001;
      if (op_valid && op_ready && op_code == OP_STOP)
        stop_q <= 1'b1;
      else if (clk_gate_n && !$past(clk_gate_n))
        stop_q <= 1'b0;
    end
  end
  // ==========================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_entry;
    push_valid ##1 vec_valid;
  endsequence
  AST_ENTRY_ORDER: assert property (push_valid |-> s_entry)
    else $error("vector fetch did not follow the stack push");
  AST_VEC_PUSHED: assert property (vec_valid |-> $past(push_valid))
    else $error("vector fetch without a prior stack push");
  AST_PUSH_PULSE: assert property (push_valid |=> !push_valid)
    else $error("push strobe longer than one cycle");
  AST_VEC_MAP: assert property (vec_valid |-> is_trap ||
    vec_addr == VEC_IRQ_BASE - {13'h0, irq_ack_idx, 1'b0})
    else $error("vector address off the map");
  AST_MASKED: assert property (push_valid && push_ccr[FB_I] |=> is_trap)
    else $error("maskable request taken with mask set");
  AST_PUSH_ONES: assert property (push_valid |-> push_ccr[6:5] == 2'b11)
    else $error("stacked flag bits 6 and 5 not one");
  AST_CCR_ONES: assert property (reg_rd && reg_addr == RA_CCR
    |=> reg_rdata[6:5] == 2'b11)
    else $error("flag bits 6 and 5 read not one");
  AST_UNMAPPED: assert property (reg_rd && reg_addr > RA_VECL
    |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_WAIT_GATE: assert property (op_valid && op_ready
    && op_code == OP_WAIT |-> ##[1:3] !clk_gate_n)
    else $error("wait did not gate the clock");
  AST_STOP_GATE: assert property (op_valid && op_ready
    && op_code == OP_STOP |-> ##[1:3] !clk_gate_n)
    else $error("stop did not gate the clock");
  AST_STAB: assert property (stop_q && $rose(clk_gate_n)
    |-> gate_cnt_q >= OSC_STAB)
    else $error("clock restarted before stabilization");
endmodule : fic_core_props
bind fic_core fic_core_props #(.OSC_STAB(OSC_STAB)) u_props (
  .clk(clk), .rstn(rstn), .op_valid(op_valid), .op_code(op_code),
  .op_ready(op_ready), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .push_valid(push_valid), .push_ccr(push_ccr),
  .vec_valid(vec_valid), .vec_addr(vec_addr),
  .irq_ack_idx(irq_ack_idx), .clk_gate_n(clk_gate_n));
`default_nettype wire

// [testbench/fic_stack_model.sv]
// partner: stack memory holding the frame pushed on interrupt entry
`timescale 1ns/1ps
`default_nettype none
module fic_stack_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic push_valid,
  input wire logic [7:0] push_ccr,
  input wire logic [7:0] push_acc,
  input wire logic [7:0] push_idxl,
  output logic [7:0] pulled_ccr,
  output logic [7:0] pulled_acc,
  output logic [7:0] pulled_idxl
);
  // ==========================================================
  // frame is three bytes only; no upper index slot exists
  // the return op pulls back exactly what was stacked
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pulled_ccr <= 8'h68;
      pulled_acc <= 8'h00;
      pulled_idxl <= 8'h00;
    end else if (push_valid) begin
      pulled_ccr <= push_ccr;
      pulled_acc <= push_acc;
      pulled_idxl <= push_idxl;
    end
  end
endmodule : fic_stack_model
`default_nettype wire

// [testbench/cpu_flag_and_interrupt_mask_core_tb.sv]
// testbench: directed scenarios for the flag and mask core
`timescale 1ns/1ps
`default_nettype none
module cpu_flag_and_interrupt_mask_core_tb;
  import fic_pkg::*;
  localparam int STAB = 8;
  logic clk = 1'b0, rstn = 1'b0, op_valid = 1'b0, ext_irq = 1'b0;
  logic [7:0] op_code = 8'h00, op_data = 8'h00, reg_wdata = 8'h00;
  logic [3:0] irq_req = 4'h0, reg_addr = 4'h0;
  logic brk_en = 1'b0, brk_req = 1'b0, mon_mode = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_rdata, push_ccr, push_acc, push_idxl, p_ccr, p_acc, p_idxl;
  logic op_ready, push_valid, vec_valid, clk_gate_n, brk_active;
  logic [15:0] vec_addr, last_vec;
  logic [1:0] irq_ack_idx, last_ack;
  logic [7:0] last_push, ec, d;
  int fails = 0, cmp_count = 0, vec_n = 0;
  always #50 clk = ~clk;
  fic_core #(.OSC_STAB(STAB)) u_dut (.clk(clk), .rstn(rstn),
    .op_valid(op_valid), .op_code(op_code), .op_data(op_data),
    .pulled_ccr(p_ccr), .pulled_acc(p_acc), .pulled_idxl(p_idxl),
    .irq_req(irq_req), .ext_irq(ext_irq), .brk_en(brk_en),
    .brk_req(brk_req), .mon_mode(mon_mode), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .op_ready(op_ready), .push_valid(push_valid),
    .push_ccr(push_ccr), .push_acc(push_acc), .push_idxl(push_idxl),
    .vec_addr(vec_addr), .vec_valid(vec_valid),
    .irq_ack_idx(irq_ack_idx), .clk_gate_n(clk_gate_n),
    .brk_active(brk_active));
  fic_stack_model u_stack (.clk(clk), .rstn(rstn),
    .push_valid(push_valid), .push_ccr(push_ccr), .push_acc(push_acc),
    .push_idxl(push_idxl), .pulled_ccr(p_ccr), .pulled_acc(p_acc),
    .pulled_idxl(p_idxl));
  // ==========================================================
  // monitor: log every vector fetch and stacked flag byte
  always @(posedge clk) begin
    if (vec_valid === 1'b1) begin
      vec_n <= vec_n + 1;
      last_vec <= vec_addr;
      last_ack <= irq_ack_idx;
    end
    if (push_valid === 1'b1) last_push <= push_ccr;
  end
  task automatic chk8(input string nm, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8
  task automatic chk16(input string nm, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk16
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // ==========================================================
  // register port and op handshake
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic issue(input logic [7:0] c, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_data <= v;
    do begin
      @(posedge clk);
      n++;
    end while (op_ready !== 1'b1 && n < 200);
    op_valid <= 1'b0;
    if (n >= 200) chk8("op taken", 8'h01, 8'h00);
  endtask : issue
  task automatic op(input logic [7:0] c, input logic [7:0] v);
    int n;
    n = 0;
    issue(c, v);
    cyc(2);
    while (op_ready !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n >= 200) chk8("op done", 8'h01, 8'h00);
  endtask : op
  // expected flags of an add, mask given by the caller
  function automatic logic [7:0] add_f(input logic [7:0] a, b,
                                        input logic ci, im);
    logic [8:0] s;
    logic [4:0] hs;
    s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    hs = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    return {(a[7] == b[7]) && (s[7] != a[7]), 2'b11, hs[4], im, s[7],
            s[7:0] == 8'h00, s[8]};
  endfunction : add_f
  function automatic logic [7:0] sh_f(input logic [7:0] a, f);
    return {a[7] ^ a[6], 2'b11, f[FB_H], f[FB_I], a[6],
            a[6:0] == 7'h00, a[7]};
  endfunction : sh_f
  // ==========================================================
  task automatic t_reset;
    rd(RA_CCR, d);
    chk8("ccr", CCR_RST, d);
    rd(RA_SPL, d);
    chk8("spl", 8'hff, d);
    rd(4'hf, d);
    chk8("unmapped", 8'h00, d);
    ec = CCR_RST;
    $display("test reset done");
  endtask : t_reset
  task automatic t_add;
    logic [23:0] tv [5];
    logic ci;
    tv = '{{OP_ADD_IMM, 8'h08, 8'h08}, {OP_ADD_IMM, 8'hff, 8'h01},
           {OP_ADC_IMM, 8'h10, 8'h0f}, {OP_ADD_IMM, 8'h7f, 8'h01},
           {OP_ADC_IMM, 8'h80, 8'h80}};
    for (int k = 0; k < 5; k++) begin
      ci = (tv[k][23:16] == OP_ADC_IMM) & ec[FB_C];
      wr(RA_ACC, tv[k][15:8]);
      op(tv[k][23:16], tv[k][7:0]);
      rd(RA_ACC, d);
      chk8("acc", tv[k][15:8] + tv[k][7:0] + {7'h0, ci}, d);
      ec = add_f(tv[k][15:8], tv[k][7:0], ci, 1'b1);
      rd(RA_CCR, d);
      chk8("ccr", ec, d);
    end
    $display("test add done");
  endtask : t_add
  task automatic t_ptr;
    wr(RA_IDXH, 8'h12);
    wr(RA_IDXL, 8'h00);
    op(OP_AIX, 8'hff);
    op(OP_AIS, 8'h80);
    rd(RA_IDXH, d);
    chk8("idxh", 8'h11, d);
    rd(RA_IDXL, d);
    chk8("idxl", 8'hff, d);
    rd(RA_SPL, d);
    chk8("spl", 8'h7f, d);
    rd(RA_CCR, d);
    chk8("ccr", ec, d);
    wr(RA_ACC, 8'h81);
    op(OP_ASLA, 8'h00);
    rd(RA_ACC, d);
    chk8("acc", 8'h02, d);
    ec = sh_f(8'h81, ec);
    op(OP_ASLX, 8'h00);
    rd(RA_IDXL, d);
    chk8("idxl", 8'hfe, d);
    ec = sh_f(8'hff, ec);
    rd(RA_CCR, d);
    chk8("ccr", ec, d);
    wr(RA_ACC, 8'h09);
    op(OP_ADD_IMM, 8'h09);
    op(OP_DAA, 8'h00);
    rd(RA_ACC, d);
    chk8("adjust", 8'h18, d);
    wr(RA_ACC, 8'h90);
    op(OP_ADD_IMM, 8'h90);
    op(OP_DAA, 8'h00);
    rd(RA_ACC, d);
    chk8("adjust", 8'h80, d);
    $display("test pointer and shift done");
  endtask : t_ptr
  task automatic t_irq;
    irq_req <= 4'b0110;
    cyc(10);
    chk16("masked", 16'd0, 16'(vec_n));
    op(OP_CLI, 8'h00);
    cyc(5);
    chk16("vector", 16'hfff8, last_vec);
    chk8("ack", 8'h01, {6'h0, last_ack});
    chk8("stacked mask", 8'h00, {7'h0, last_push[FB_I]});
    rd(RA_CCR, d);
    chk8("mask", 8'h01, {7'h0, d[FB_I]});
    irq_req <= 4'h0;
    op(OP_RTI, 8'h00);
    rd(RA_CCR, d);
    chk8("mask", 8'h00, {7'h0, d[FB_I]});
    rd(RA_ACC, d);
    chk8("acc", 8'h80, d);
    $display("test interrupt done");
  endtask : t_irq
  task automatic t_brk;
    brk_en <= 1'b1;
    mon_mode <= 1'b1;
    brk_req <= 1'b1;
    op(OP_ADD_IMM, 8'h01);
    cyc(6);
    chk16("vector", VEC_SWI_MON, last_vec);
    chk8("break", 8'h01, {7'h0, brk_active});
    brk_req <= 1'b0; // request gone before the return
    op(OP_RTI, 8'h00);
    chk8("break", 8'h00, {7'h0, brk_active});
    brk_en <= 1'b0;
    mon_mode <= 1'b0;
    op(OP_SWI, 8'h00);
    cyc(4);
    chk16("vector", VEC_SWI, last_vec);
    op(OP_RTI, 8'h00);
    $display("test break done");
  endtask : t_brk
  task automatic t_low;
    int n, v0;
    issue(OP_WAIT, 8'h00);
    cyc(4);
    chk8("gate", 8'h00, {7'h0, clk_gate_n});
    irq_req <= 4'b1000;
    cyc(8);
    chk16("vector", 16'hfff4, last_vec);
    chk8("stacked mask", 8'h00, {7'h0, last_push[FB_I]});
    irq_req <= 4'h0;
    op(OP_RTI, 8'h00);
    issue(OP_STOP, 8'h00);
    cyc(3);
    chk8("gate", 8'h00, {7'h0, clk_gate_n});
    v0 = vec_n;
    ext_irq <= 1'b1;
    n = 0;
    while (clk_gate_n !== 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
    ext_irq <= 1'b0;
    chk8("stab", 8'h01, {7'h0, n >= STAB && n < 500});
    op(OP_SEI - 8'h01, 8'h00);
    rd(RA_CCR, d);
    if (vec_n > v0) d = last_push;
    chk8("mask", 8'h00, {7'h0, d[FB_I]});
    rstn <= 1'b0;
    cyc(2);
    rstn <= 1'b1;
    rd(RA_CCR, d);
    chk8("ccr", CCR_RST, d);
    $display("test low power done");
  endtask : t_low
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // ==========================================================
  initial begin
    cyc(3);
    rstn <= 1'b1;
    t_reset();
    t_add();
    t_ptr();
    t_irq();
    t_brk();
    t_low();
    finish_test();
  end
  // watchdog well beyond the few hundred cycles the run needs
  initial begin
    #3000000;
    fails++;
    finish_test();
  end
endmodule : cpu_flag_and_interrupt_mask_core_tb
`default_nettype wire
